// *** design/snqd_pkg.sv ***
package snqd_pkg;

    localparam int SNQD_ADDR_W = 8;
    localparam int SNQD_MAX_IF = 4;

    // register byte offsets
    localparam logic [7:0] SNQD_OFF_BURST_SPLIT = 8'h00;
    localparam logic [7:0] SNQD_OFF_REMAP = 8'h04;
    localparam logic [7:0] SNQD_OFF_DEBUG_MON = 8'h08;
    localparam logic [7:0] SNQD_OFF_QOS_CTL = 8'h0C;
    localparam logic [7:0] SNQD_OFF_WDATA_THR = 8'h10;
    localparam logic [7:0] SNQD_OFF_SECURE_ACC = 8'h14;
    localparam logic [7:0] SNQD_OFF_OT_CTL = 8'h18;
    // per-interface banks, one word per interface
    localparam logic [3:0] SNQD_BANK_RD_OVR = 4'h4;
    localparam logic [3:0] SNQD_BANK_WR_OVR = 4'h5;
    localparam logic [3:0] SNQD_BANK_AT_LIMIT = 4'h6;

    // burst split control fields
    localparam int SNQD_BS_CODE_LSB = 0;
    localparam int SNQD_BS_ALL_BIT = 3;
    localparam int SNQD_BS_RD_LSB = 4;
    localparam int SNQD_BS_WR_LSB = 7;
    localparam logic [2:0] SNQD_BS_CODE_MIN = 3'h2;
    localparam logic [2:0] SNQD_BS_CODE_NOSPLIT = 3'h7;
    localparam int SNQD_BS_SHIFT_BASE = 5;
    localparam logic [3:0] SNQD_BS_RESET = 4'h7;

    // debug monitor fields
    localparam int SNQD_DBG_CAP_BIT = 31;
    localparam int SNQD_DBG_WR_LSB = 20;
    localparam int SNQD_DBG_RD_LSB = 8;
    localparam int SNQD_DBG_STALL_LSB = 0;

    // qos control fields
    localparam int SNQD_QOS_OVR_BIT = 0;
    localparam int SNQD_QOS_TSPEC_LSB = 1;
    localparam int SNQD_QOS_BQV_LSB = 4;

    localparam logic [7:0] SNQD_REMAP_RESET = 8'h00;
    localparam logic [6:0] SNQD_QOS_CTL_RESET = 7'h00;
    localparam logic [4:0] SNQD_WDATA_THR_RESET = 5'h00;
    localparam logic [3:0] SNQD_QOS_OVR_RESET = 4'h0;
    localparam logic [9:0] SNQD_AT_LIMIT_RESET = 10'h000;
    localparam logic [1:0] SNQD_SECURE_RESET = 2'h0;

    // avalon response codes
    localparam logic [1:0] SNQD_RESP_OKAY = 2'h0;
    localparam logic [1:0] SNQD_RESP_SLVERR = 2'h2;
    localparam logic [1:0] SNQD_RESP_DECERR = 2'h3;

    typedef enum logic [3:0] {
        SNQD_SEL_NONE = 4'b0000,
        SNQD_SEL_BURST = 4'b0001,
        SNQD_SEL_REMAP = 4'b0010,
        SNQD_SEL_DEBUG = 4'b0011,
        SNQD_SEL_QOS = 4'b0100,
        SNQD_SEL_WTHR = 4'b0101,
        SNQD_SEL_SECURE = 4'b0110,
        SNQD_SEL_OT = 4'b0111,
        SNQD_SEL_RD_OVR = 4'b1000,
        SNQD_SEL_WR_OVR = 4'b1001,
        SNQD_SEL_AT_LIMIT = 4'b1010
    } snqd_sel_e;

endpackage

// *** design/snqd_split_if.sv ***
`timescale 1ns/1ns
`default_nettype none

interface snqd_split_if;
    logic [2:0] cfg_code;
    logic cfg_all;
    logic [2:0] applied_wr;
    logic [2:0] applied_rd;
    logic applied_all;

    modport ctrl (output cfg_code, output cfg_all, input applied_wr, input applied_rd, input applied_all);
    modport unit (input cfg_code, input cfg_all, output applied_wr, output applied_rd, output applied_all);
endinterface

`default_nettype wire

// *** design/snqd_split_unit.sv ***
`timescale 1ns/1ns
`default_nettype none

module snqd_split_unit
    import snqd_pkg::*;
#(
    parameter logic [2:0] STRIPE_CODE = 3'h7
) (
    input wire logic i_clk_sys,
    input wire logic i_reset,
    snqd_split_if.unit bus,
    input wire logic i_wr_busy,
    input wire logic i_rd_busy,
    input wire logic [11:0] i_txn_addr,
    input wire logic [12:0] i_txn_bytes,
    input wire logic i_txn_striped,
    input wire logic i_txn_modifiable,
    output logic o_txn_split
);

    typedef struct packed {
        logic [2:0] code;
        logic all;
    } snqd_split_s;

    snqd_split_s state_reg;
    snqd_split_s state_next;
    logic [2:0] eff_code;
    logic [12:0] size_bytes;
    logic [12:0] offset;
    logic crosses;

    function automatic logic [2:0] snqd_min3(input logic [2:0] a, input logic [2:0] b);
        return (a < b) ? a : b;
    endfunction

    always_comb begin
        state_next = state_reg;
        if (!i_wr_busy && !i_rd_busy) begin
            state_next = '{code: bus.cfg_code, all: bus.cfg_all};
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (i_reset) begin
            state_reg <= '{code: SNQD_BS_RESET[2:0], all: SNQD_BS_RESET[SNQD_BS_ALL_BIT]};
        end else begin
            state_reg <= state_next;
        end
    end

    // codes below the smallest size are clamped up
    assign eff_code = snqd_min3(STRIPE_CODE, (state_reg.code < SNQD_BS_CODE_MIN) ? SNQD_BS_CODE_MIN : state_reg.code);
    assign bus.applied_wr = eff_code;
    assign bus.applied_rd = eff_code;
    assign bus.applied_all = state_reg.all;
    assign size_bytes = 13'h0001 << (4'(eff_code) + 4'(SNQD_BS_SHIFT_BASE));
    assign offset = {1'b0, i_txn_addr} & (size_bytes - 13'h0001);
    assign crosses = (eff_code != SNQD_BS_CODE_NOSPLIT) && (({1'b0, offset} + {1'b0, i_txn_bytes}) > {1'b0, size_bytes});

    always_comb begin
        o_txn_split = 1'b0;
        if (i_txn_striped) begin
            o_txn_split = crosses;
        end else if (i_txn_modifiable) begin
            o_txn_split = crosses && state_reg.all;
        end
    end

endmodule

`default_nettype wire

// *** design/snqd_regs.sv ***
`timescale 1ns/1ns
`default_nettype none

module snqd_regs
    import snqd_pkg::*;
#(
    parameter int NUM_IF = 1,
    parameter logic [2:0] STRIPE_CODE = 3'h7
) (
    input wire logic i_clk_sys,
    input wire logic i_reset,
    input wire logic [7:0] i_avs_address,
    input wire logic i_avs_read,
    input wire logic i_avs_write,
    input wire logic [31:0] i_avs_writedata,
    input wire logic [3:0] i_avs_byteenable,
    input wire logic i_avs_nonsecure,
    output logic [31:0] o_avs_readdata,
    output logic o_avs_waitrequest,
    output logic [1:0] o_avs_response,
    input wire logic i_split_wr_busy,
    input wire logic i_split_rd_busy,
    input wire logic [11:0] i_txn_addr,
    input wire logic [12:0] i_txn_bytes,
    input wire logic i_txn_striped,
    input wire logic i_txn_modifiable,
    output logic o_txn_split,
    output logic [7:0] o_remap_state,
    output logic o_remap_active,
    input wire logic [4:0] i_chan_stall,
    input wire logic [8:0] i_outstanding_writes,
    input wire logic [8:0] i_outstanding_reads,
    output logic [2:0] o_bqv_enable,
    output logic [2:0] o_tspec_enable,
    input wire logic i_qos_replace_pin,
    input wire logic [NUM_IF-1:0][3:0] i_arqos,
    input wire logic [NUM_IF-1:0][3:0] i_awqos,
    output logic [NUM_IF-1:0][3:0] o_arqos,
    output logic [NUM_IF-1:0][3:0] o_awqos,
    input wire logic i_wbeat,
    input wire logic i_wlast,
    output logic o_wpacket_send,
    input wire logic [NUM_IF-1:0] i_atomic_req,
    input wire logic [NUM_IF-1:0] i_atomic_done,
    output logic [NUM_IF-1:0] o_atomic_stall
);

    typedef struct packed {
        logic ack;
        logic [31:0] rdata;
        logic [1:0] resp;
        logic [3:0] split_cfg;
        logic [7:0] remap;
        logic cap_en;
        logic [8:0] dbg_wr;
        logic [8:0] dbg_rd;
        logic [4:0] dbg_stall;
        logic [6:0] qos_ctl;
        logic [4:0] wthr;
        logic [4:0] wcnt;
        logic wsend;
        logic [1:0] sec_acc;
        logic ot_en;
        logic [NUM_IF-1:0][3:0] rd_ovr;
        logic [NUM_IF-1:0][3:0] wr_ovr;
        logic [NUM_IF-1:0][3:0] arqos_q;
        logic [NUM_IF-1:0][3:0] awqos_q;
        logic [NUM_IF-1:0][9:0] at_limit;
        logic [NUM_IF-1:0][9:0] at_cnt;
    } snqd_state_s;

    snqd_state_s state_reg;
    snqd_state_s state_next;
    snqd_split_if split_bus();
    snqd_sel_e sel;
    logic [1:0] sel_idx;
    logic req;
    logic allowed;
    logic commit;
    logic ovr_active;
    logic [5:0] beat_total;
    logic [5:0] beat_need;

    function automatic snqd_sel_e snqd_decode(input logic [7:0] addr);
        snqd_sel_e s;
        s = SNQD_SEL_NONE;
        if (addr[1:0] == 2'h0) begin
            unique case (addr)
                SNQD_OFF_BURST_SPLIT: s = SNQD_SEL_BURST;
                SNQD_OFF_REMAP: s = SNQD_SEL_REMAP;
                SNQD_OFF_DEBUG_MON: s = SNQD_SEL_DEBUG;
                SNQD_OFF_QOS_CTL: s = SNQD_SEL_QOS;
                SNQD_OFF_WDATA_THR: s = SNQD_SEL_WTHR;
                SNQD_OFF_SECURE_ACC: s = SNQD_SEL_SECURE;
                SNQD_OFF_OT_CTL: s = SNQD_SEL_OT;
                default: begin
                    if (32'(addr[3:2]) < NUM_IF) begin
                        if (addr[7:4] == SNQD_BANK_RD_OVR) begin
                            s = SNQD_SEL_RD_OVR;
                        end else if (addr[7:4] == SNQD_BANK_WR_OVR) begin
                            s = SNQD_SEL_WR_OVR;
                        end else if (addr[7:4] == SNQD_BANK_AT_LIMIT) begin
                            s = SNQD_SEL_AT_LIMIT;
                        end
                    end
                end
            endcase
        end
        return s;
    endfunction

    function automatic logic [31:0] snqd_merge(input logic [31:0] old, input logic [31:0] wd, input logic [3:0] be);
        logic [31:0] m;
        m = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
        return (old & ~m) | (wd & m);
    endfunction

    function automatic logic [7:0] snqd_lowest(input logic [7:0] v);
        return v & (~v + 8'h01);
    endfunction

    snqd_split_unit #(
        .STRIPE_CODE(STRIPE_CODE)
    ) u_split (
        .i_clk_sys(i_clk_sys),
        .i_reset(i_reset),
        .bus(split_bus),
        .i_wr_busy(i_split_wr_busy),
        .i_rd_busy(i_split_rd_busy),
        .i_txn_addr(i_txn_addr),
        .i_txn_bytes(i_txn_bytes),
        .i_txn_striped(i_txn_striped),
        .i_txn_modifiable(i_txn_modifiable),
        .o_txn_split(o_txn_split)
    );

    // staged bits only reach the unit when idle
    assign split_bus.cfg_code = state_reg.split_cfg[2:0];
    assign split_bus.cfg_all = state_reg.split_cfg[SNQD_BS_ALL_BIT];

    assign req = i_avs_read || i_avs_write;
    assign sel = snqd_decode(i_avs_address);
    assign sel_idx = i_avs_address[3:2];
    assign allowed = !i_avs_nonsecure || ((sel != SNQD_SEL_SECURE) && (state_reg.sec_acc != 2'h0));
    // writes land on the edge where waitrequest is low
    assign commit = i_avs_write && state_reg.ack && allowed && (sel != SNQD_SEL_NONE);
    assign ovr_active = (i_qos_replace_pin || state_reg.qos_ctl[SNQD_QOS_OVR_BIT])
        && (state_reg.qos_ctl[SNQD_QOS_BQV_LSB +: 3] == 3'h0);
    assign beat_total = {1'b0, state_reg.wcnt} + 6'h01;
    assign beat_need = (state_reg.wthr == 5'h00) ? 6'h01 : {1'b0, state_reg.wthr};

    always_comb begin
        state_next = state_reg;
        state_next.wsend = 1'b0;
        // one wait cycle, then answer; ack drops so back-to-back requests each wait
        state_next.ack = req && !state_reg.ack;

        if (req && !state_reg.ack) begin
            state_next.rdata = 32'h0000_0000;
            state_next.resp = SNQD_RESP_OKAY;
            if (sel == SNQD_SEL_NONE) begin
                state_next.resp = SNQD_RESP_DECERR;
            end else if (!allowed) begin
                state_next.resp = SNQD_RESP_SLVERR;
            end else begin
                unique case (sel)
                    SNQD_SEL_BURST: begin
                        state_next.rdata[3:0] = state_reg.split_cfg;
                        state_next.rdata[SNQD_BS_RD_LSB +: 3] = split_bus.applied_rd;
                        state_next.rdata[SNQD_BS_WR_LSB +: 3] = split_bus.applied_wr;
                    end
                    SNQD_SEL_REMAP: state_next.rdata[7:0] = state_reg.remap;
                    SNQD_SEL_DEBUG: begin
                        state_next.rdata[SNQD_DBG_CAP_BIT] = state_reg.cap_en;
                        state_next.rdata[SNQD_DBG_WR_LSB +: 9] = state_reg.dbg_wr;
                        state_next.rdata[SNQD_DBG_RD_LSB +: 9] = state_reg.dbg_rd;
                        state_next.rdata[SNQD_DBG_STALL_LSB +: 5] = state_reg.dbg_stall;
                    end
                    SNQD_SEL_QOS: state_next.rdata[6:0] = state_reg.qos_ctl;
                    SNQD_SEL_WTHR: state_next.rdata[4:0] = state_reg.wthr;
                    SNQD_SEL_SECURE: state_next.rdata[1:0] = state_reg.sec_acc;
                    SNQD_SEL_OT: state_next.rdata[0] = state_reg.ot_en;
                    SNQD_SEL_RD_OVR: state_next.rdata[3:0] = state_reg.rd_ovr[sel_idx];
                    SNQD_SEL_WR_OVR: state_next.rdata[3:0] = state_reg.wr_ovr[sel_idx];
                    SNQD_SEL_AT_LIMIT: state_next.rdata[9:0] = state_reg.at_limit[sel_idx];
                    default: state_next.rdata = 32'h0000_0000;
                endcase
            end
        end

        if (commit) begin
            unique case (sel)
                SNQD_SEL_BURST: begin
                    state_next.split_cfg = 4'(snqd_merge({28'h0, state_reg.split_cfg}, i_avs_writedata,
                        i_avs_byteenable));
                end
                SNQD_SEL_REMAP: begin
                    state_next.remap = 8'(snqd_merge({24'h0, state_reg.remap}, i_avs_writedata, i_avs_byteenable));
                end
                SNQD_SEL_DEBUG: begin
                    if (i_avs_byteenable[3]) begin
                        state_next.cap_en = i_avs_writedata[SNQD_DBG_CAP_BIT];
                    end
                end
                SNQD_SEL_QOS: begin
                    state_next.qos_ctl = 7'(snqd_merge({25'h0, state_reg.qos_ctl}, i_avs_writedata,
                        i_avs_byteenable));
                end
                SNQD_SEL_WTHR: begin
                    state_next.wthr = 5'(snqd_merge({27'h0, state_reg.wthr}, i_avs_writedata, i_avs_byteenable));
                end
                SNQD_SEL_SECURE: begin
                    state_next.sec_acc = 2'(snqd_merge({30'h0, state_reg.sec_acc}, i_avs_writedata,
                        i_avs_byteenable));
                end
                SNQD_SEL_OT: begin
                    if (i_avs_byteenable[0]) begin
                        state_next.ot_en = i_avs_writedata[0];
                    end
                end
                // each interface has its own word
                SNQD_SEL_RD_OVR: begin
                    state_next.rd_ovr[sel_idx] = 4'(snqd_merge({28'h0, state_reg.rd_ovr[sel_idx]}, i_avs_writedata,
                        i_avs_byteenable));
                end
                SNQD_SEL_WR_OVR: begin
                    state_next.wr_ovr[sel_idx] = 4'(snqd_merge({28'h0, state_reg.wr_ovr[sel_idx]}, i_avs_writedata,
                        i_avs_byteenable));
                end
                SNQD_SEL_AT_LIMIT: begin
                    state_next.at_limit[sel_idx] = 10'(snqd_merge({22'h0, state_reg.at_limit[sel_idx]},
                        i_avs_writedata, i_avs_byteenable));
                end
                default: state_next.ot_en = state_reg.ot_en;
            endcase
        end

        // snapshot freezes when capture is off, so software reads a coherent set
        if (state_reg.cap_en) begin
            state_next.dbg_wr = i_outstanding_writes;
            state_next.dbg_rd = i_outstanding_reads;
            state_next.dbg_stall = i_chan_stall;
        end

        if (i_wbeat) begin
            if ((beat_total >= beat_need) || i_wlast) begin
                state_next.wsend = 1'b1;
                state_next.wcnt = 5'h00;
            end else begin
                state_next.wcnt = beat_total[4:0];
            end
        end

        for (int i = 0; i < NUM_IF; i++) begin
            state_next.arqos_q[i] = ovr_active ? state_reg.rd_ovr[i] : i_arqos[i];
            state_next.awqos_q[i] = ovr_active ? state_reg.wr_ovr[i] : i_awqos[i];
            if (i_atomic_req[i] && !i_atomic_done[i] && (state_reg.at_cnt[i] != 10'h3FF)) begin
                state_next.at_cnt[i] = state_reg.at_cnt[i] + 10'h001;
            end else if (!i_atomic_req[i] && i_atomic_done[i] && (state_reg.at_cnt[i] != 10'h000)) begin
                state_next.at_cnt[i] = state_reg.at_cnt[i] - 10'h001;
            end
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (i_reset) begin
            state_reg <= '0;
            state_reg.split_cfg <= SNQD_BS_RESET;
            state_reg.remap <= SNQD_REMAP_RESET;
            state_reg.qos_ctl <= SNQD_QOS_CTL_RESET;
            state_reg.wthr <= SNQD_WDATA_THR_RESET;
            state_reg.sec_acc <= SNQD_SECURE_RESET;
            state_reg.rd_ovr <= {NUM_IF{SNQD_QOS_OVR_RESET}};
            state_reg.wr_ovr <= {NUM_IF{SNQD_QOS_OVR_RESET}};
            state_reg.at_limit <= {NUM_IF{SNQD_AT_LIMIT_RESET}};
        end else begin
            state_reg <= state_next;
        end
    end

    // stall is a level; the master holds new atomics while it stands
    generate
        for (genvar g = 0; g < NUM_IF; g++) begin : g_atomic
            // stall new atomics at the limit
            assign o_atomic_stall[g] = state_reg.ot_en && (state_reg.at_cnt[g] >= state_reg.at_limit[g]);
        end
    endgenerate

    // readdata is registered, so each request costs one wait state
    assign o_avs_waitrequest = req && !state_reg.ack;
    assign o_avs_readdata = state_reg.rdata;
    assign o_avs_response = state_reg.resp;
    // decoder sees one state even when several bits are set
    assign o_remap_state = snqd_lowest(state_reg.remap);
    assign o_remap_active = (state_reg.remap != 8'h00);
    assign o_bqv_enable = state_reg.qos_ctl[SNQD_QOS_BQV_LSB +: 3];
    assign o_tspec_enable = state_reg.qos_ctl[SNQD_QOS_TSPEC_LSB +: 3];
    assign o_arqos = state_reg.arqos_q;
    assign o_awqos = state_reg.awqos_q;
    assign o_wpacket_send = state_reg.wsend;

endmodule

`default_nettype wire

// *** tb/snqd_regs_chk.sv ***
`timescale 1ns/1ns
`default_nettype none
module snqd_regs_chk
    import snqd_pkg::*;
#(
    parameter int NUM_IF = 1
) (
    input wire logic i_clk_sys,
    input wire logic i_reset,
    input wire logic [7:0] i_avs_address,
    input wire logic i_avs_read,
    input wire logic i_avs_write,
    input wire logic [31:0] i_avs_writedata,
    input wire logic i_avs_nonsecure,
    input wire logic [31:0] o_avs_readdata,
    input wire logic o_avs_waitrequest,
    input wire logic [1:0] o_avs_response,
    input wire logic [11:0] i_txn_addr,
    input wire logic [12:0] i_txn_bytes,
    input wire logic i_txn_striped,
    input wire logic i_txn_modifiable,
    input wire logic o_txn_split,
    input wire logic [7:0] o_remap_state,
    input wire logic [2:0] o_bqv_enable,
    input wire logic [2:0] o_tspec_enable,
    input wire logic [NUM_IF-1:0][3:0] i_arqos,
    input wire logic [NUM_IF-1:0][3:0] o_arqos,
    input wire logic i_wbeat,
    input wire logic i_wlast,
    input wire logic o_wpacket_send
);
    default clocking @(posedge i_clk_sys); endclocking
    default disable iff (i_reset);
    // secure write taken at this edge
    wire wr_ok = i_avs_write && !o_avs_waitrequest && !i_avs_nonsecure;
    wire [7:0] wd = i_avs_writedata[7:0];
    wire [13:0] txn_end = {2'h0, i_txn_addr} + {1'h0, i_txn_bytes};
    a_remap_lowest_bit: assert property (wr_ok && i_avs_address == SNQD_OFF_REMAP |=>
        o_remap_state == $past(wd & (~wd + 8'h01))) else $error("remap state not lowest set bit");
    a_qos_enables_split: assert property (wr_ok && i_avs_address == SNQD_OFF_QOS_CTL |=>
        {o_bqv_enable, o_tspec_enable} == $past(wd[6:1])) else $error("regulator enables wrong");
    a_bqv_blocks_override: assert property (o_bqv_enable != 3'h0 |=> o_arqos == $past(i_arqos))
        else $error("override applied with latency regulator on");
    a_last_beat_sends: assert property (i_wbeat && i_wlast |=> o_wpacket_send)
        else $error("no packet after last beat");
    a_secure_reg_refused: assert property (i_avs_nonsecure && (i_avs_read || i_avs_write) &&
        !o_avs_waitrequest && i_avs_address == SNQD_OFF_SECURE_ACC |-> o_avs_response == SNQD_RESP_SLVERR)
        else $error("non-secure access to secure control not refused");
    a_reserved_reads_zero: assert property (i_avs_read && !o_avs_waitrequest &&
        i_avs_address == SNQD_OFF_REMAP |-> o_avs_readdata[31:8] == 24'h0) else $error("reserved bits not zero");
    a_striped_cross_split: assert property (i_txn_striped && txn_end > 14'h1000 |-> o_txn_split)
        else $error("striped crossing not split");
    a_unstriped_fixed_whole: assert property (!i_txn_striped && !i_txn_modifiable |-> !o_txn_split)
        else $error("non-modifiable unstriped split");
endmodule
bind snqd_regs snqd_regs_chk #(.NUM_IF(NUM_IF)) chk (.i_clk_sys(i_clk_sys), .i_reset(i_reset),
    .i_avs_address(i_avs_address), .i_avs_read(i_avs_read), .i_avs_write(i_avs_write),
    .i_avs_writedata(i_avs_writedata), .i_avs_nonsecure(i_avs_nonsecure), .o_avs_readdata(o_avs_readdata),
    .o_avs_waitrequest(o_avs_waitrequest), .o_avs_response(o_avs_response), .i_txn_addr(i_txn_addr),
    .i_txn_bytes(i_txn_bytes), .i_txn_striped(i_txn_striped), .i_txn_modifiable(i_txn_modifiable),
    .o_txn_split(o_txn_split), .o_remap_state(o_remap_state), .o_bqv_enable(o_bqv_enable),
    .o_tspec_enable(o_tspec_enable), .i_arqos(i_arqos), .o_arqos(o_arqos), .i_wbeat(i_wbeat),
    .i_wlast(i_wlast), .o_wpacket_send(o_wpacket_send));
`default_nettype wire

// *** tb/snqd_axi_master.sv ***
`timescale 1ns/1ns
`default_nettype none
module snqd_axi_master #(
    parameter int NUM_IF = 2
) (
    input wire logic i_clk_sys,
    output logic [NUM_IF-1:0][3:0] o_arqos,
    output logic [NUM_IF-1:0][3:0] o_awqos,
    output logic [4:0] o_stall,
    output logic [8:0] o_ot_wr,
    output logic [8:0] o_ot_rd,
    output logic o_wbeat,
    output logic o_wlast,
    output logic [NUM_IF-1:0] o_atomic_req,
    output logic [NUM_IF-1:0] o_atomic_done
);
    initial {o_arqos, o_awqos, o_stall, o_ot_wr, o_ot_rd, o_wbeat, o_wlast, o_atomic_req, o_atomic_done} = '0;
    task automatic level(input logic [NUM_IF-1:0][3:0] ar, aw, input logic [4:0] st, input logic [8:0] w, r);
        @(posedge i_clk_sys);
        {o_arqos, o_awqos, o_stall, o_ot_wr, o_ot_rd} <= {ar, aw, st, w, r};
    endtask
    task automatic beats(input int n, input logic last);
        for (int k = 0; k < n; k++) begin
            @(posedge i_clk_sys);
            {o_wbeat, o_wlast} <= {1'b1, last && k == n - 1};
        end
        @(posedge i_clk_sys);
        {o_wbeat, o_wlast} <= 2'b00;
    endtask
    task automatic atomic(input logic [NUM_IF-1:0] req, done);
        @(posedge i_clk_sys);
        {o_atomic_req, o_atomic_done} <= {req, done};
        @(posedge i_clk_sys);
        {o_atomic_req, o_atomic_done} <= '0;
    endtask
endmodule
`default_nettype wire

// *** tb/slave_node_qos_debug_regs_test.sv ***
`timescale 1ns/1ns
`default_nettype none
module slave_node_qos_debug_regs_test;
    import snqd_pkg::*;
    localparam int NUM_IF = 2;
    typedef struct {logic [7:0] a; logic [31:0] d; logic [31:0] e; logic [1:0] r;} snqd_row_s;
    logic clk = 0, rst = 1, rd = 0, wr = 0, ns = 0, pin = 0, wbusy = 0, striped = 0, modif = 0;
    logic split, active, send, wbeat, wlast, wait_r;
    logic [7:0] addr = '0, rstate;
    logic [31:0] wdata = '0, q, rdata;
    logic [1:0] resp, r;
    logic [11:0] taddr = '0;
    logic [12:0] tbytes = '0;
    logic [2:0] bqv, tspec;
    logic [4:0] stall;
    logic [8:0] otw, otr;
    logic [NUM_IF-1:0][3:0] arq, awq, oarq, oawq;
    logic [NUM_IF-1:0] areq, adone, astall;
    int miscompares = 0, checked = 0, cyc = 0, sends = 0;
    snqd_row_s rows[12] = '{
        '{SNQD_OFF_REMAP, 32'hFFFFFFFF, 32'hFF, SNQD_RESP_OKAY}, '{SNQD_OFF_QOS_CTL, 32'hFFFFFFFF, 32'h7F, 2'h0},
        '{SNQD_OFF_WDATA_THR, 32'hFFFFFFFF, 32'h1F, 2'h0}, '{8'h40, 32'hFFFFFFFF, 32'hF, 2'h0},
        '{8'h44, 32'h5, 32'h5, 2'h0}, '{8'h50, 32'hFFFFFFFF, 32'hF, 2'h0}, '{8'h54, 32'h3, 32'h3, 2'h0},
        '{8'h60, 32'hFFFFFFFF, 32'h3FF, 2'h0}, '{8'h64, 32'h1FF, 32'h1FF, 2'h0},
        '{SNQD_OFF_OT_CTL, 32'h1, 32'h1, 2'h0}, '{SNQD_OFF_BURST_SPLIT, 32'h3, 32'h1B3, 2'h0},
        '{8'hFC, 32'h1, 32'h0, SNQD_RESP_DECERR}};
    always #50 clk = ~clk;
    snqd_regs #(.NUM_IF(NUM_IF)) uut (.i_clk_sys(clk), .i_reset(rst), .i_avs_address(addr), .i_avs_read(rd),
        .i_avs_write(wr), .i_avs_writedata(wdata), .i_avs_byteenable(4'hF), .i_avs_nonsecure(ns),
        .o_avs_readdata(rdata), .o_avs_waitrequest(wait_r), .o_avs_response(resp), .i_split_wr_busy(wbusy),
        .i_split_rd_busy(1'b0), .i_txn_addr(taddr), .i_txn_bytes(tbytes), .i_txn_striped(striped),
        .i_txn_modifiable(modif), .o_txn_split(split), .o_remap_state(rstate), .o_remap_active(active),
        .i_chan_stall(stall), .i_outstanding_writes(otw), .i_outstanding_reads(otr), .o_bqv_enable(bqv),
        .o_tspec_enable(tspec), .i_qos_replace_pin(pin), .i_arqos(arq), .i_awqos(awq), .o_arqos(oarq),
        .o_awqos(oawq), .i_wbeat(wbeat), .i_wlast(wlast), .o_wpacket_send(send), .i_atomic_req(areq),
        .i_atomic_done(adone), .o_atomic_stall(astall));
    snqd_axi_master #(.NUM_IF(NUM_IF)) mst (.i_clk_sys(clk), .o_arqos(arq), .o_awqos(awq), .o_stall(stall),
        .o_ot_wr(otw), .o_ot_rd(otr), .o_wbeat(wbeat), .o_wlast(wlast), .o_atomic_req(areq),
        .o_atomic_done(adone));
    task automatic finish_test;
        $display("checks %0d mismatches %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    task automatic chk(input string n, input logic [31:0] s, e);
        checked++;
        if (s !== e) begin
            miscompares++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, s);
        end
    endtask
    // hold the request until waitrequest is seen low, then release
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, input logic n);
        @(posedge clk);
        {rd, wr, addr, wdata, ns} <= {!w, w, a, d, n};
        do @(posedge clk); while (wait_r !== 1'b0);
        {q, r} = {rdata, resp};
        {rd, wr} <= 2'b00;
    endtask
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (send === 1'b1) sends <= sends + 1;
        if (cyc == 3000) begin
            miscompares++;
            finish_test();
        end
    end
    initial begin
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        bus(0, SNQD_OFF_BURST_SPLIT, 0, 0);
        chk("split reset", q, 32'h3F7);
        bus(0, SNQD_OFF_REMAP, 0, 1);
        chk("refused", {q[29:0], r}, {30'h0, SNQD_RESP_SLVERR});
        bus(1, SNQD_OFF_SECURE_ACC, 32'h2, 0);
        bus(0, SNQD_OFF_REMAP, 0, 1);
        chk("granted", {30'h0, r}, {30'h0, SNQD_RESP_OKAY});
        bus(1, SNQD_OFF_SECURE_ACC, 32'h0, 1);
        chk("sec ctl", {30'h0, r}, {30'h0, SNQD_RESP_SLVERR});
        $display("test security done");
        foreach (rows[i]) begin
            bus(1, rows[i].a, rows[i].d, 0);
            bus(0, rows[i].a, 0, 0);
            chk($sformatf("reg %h", rows[i].a), {q[29:0], r}, {rows[i].e[29:0], rows[i].r});
        end
        $display("test registers done");
        wbusy <= 1'b1;
        bus(1, SNQD_OFF_BURST_SPLIT, 32'h2, 0);
        bus(0, SNQD_OFF_BURST_SPLIT, 0, 0);
        chk("split held", q, 32'h1B2);
        wbusy <= 1'b0;
        bus(0, SNQD_OFF_BURST_SPLIT, 0, 0);
        chk("split applied", q, 32'h122);
        {taddr, tbytes, striped, modif} <= {12'hFFC, 13'h8, 2'b11};
        repeat (2) @(posedge clk);
        chk("striped", split, 1);
        {striped, modif} <= 2'b00;
        repeat (2) @(posedge clk);
        chk("unstriped", split, 0);
        bus(1, SNQD_OFF_REMAP, 32'h0C, 0);
        repeat (2) @(posedge clk);
        chk("remap", {active, rstate}, 9'h104);
        $display("test split remap done");
        mst.level({4'h9, 4'h1}, {4'h6, 4'h2}, 5'h15, 9'h1A5, 9'h0C3);
        bus(1, SNQD_OFF_QOS_CTL, 32'h1, 0);
        repeat (2) @(posedge clk);
        chk("qos ovr", {oarq, oawq}, 16'h5F3F);
        bus(1, SNQD_OFF_QOS_CTL, 32'h11, 0);
        repeat (2) @(posedge clk);
        chk("qos bqv", {bqv, tspec, oarq}, 14'h0891);
        pin <= 1'b1;
        bus(1, SNQD_OFF_QOS_CTL, 32'h0, 0);
        repeat (2) @(posedge clk);
        chk("qos pin", oarq, 8'h5F);
        bus(1, SNQD_OFF_DEBUG_MON, 32'h80000000, 0);
        bus(0, SNQD_OFF_DEBUG_MON, 0, 0);
        chk("monitor", q, {1'b1, 2'b0, 9'h1A5, 3'b0, 9'h0C3, 3'b0, 5'h15});
        $display("test qos monitor done");
        bus(1, SNQD_OFF_WDATA_THR, 32'h3, 0);
        mst.beats(2, 0);
        repeat (2) @(posedge clk);
        chk("below thr", sends, 0);
        mst.beats(1, 0);
        repeat (2) @(posedge clk);
        chk("at thr", sends, 1);
        mst.beats(1, 1);
        repeat (2) @(posedge clk);
        chk("last", sends, 2);
        bus(1, 8'h60, 32'h2, 0);
        mst.atomic(2'b01, 2'b00);
        mst.atomic(2'b01, 2'b00);
        repeat (2) @(posedge clk);
        chk("at limit", astall, 2'b01);
        mst.atomic(2'b00, 2'b01);
        repeat (2) @(posedge clk);
        chk("below limit", astall, 2'b00);
        $display("test buffer atomic done");
        finish_test();
    end
endmodule
`default_nettype wire
